// file: rtl/dac_chan.sv
// one converter channel: data bytes, pending and live code
`timescale 1ns/1ps
module dac_chan
  import dac_ctl_pkg::*;
#(
  parameter int CW = CODE_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic mode8_i,
  input wire logic sync_i,
  input wire logic sync_rise_i,
  output logic [DATA_W-1:0] low_o,
  output logic [DATA_W-1:0] high_o,
  output logic [CW-1:0] code_o
);
  logic [DATA_W-1:0] next_low;
  logic [DATA_W-1:0] next_high;
  logic [CW-1:0] next_code;
  logic [CW-1:0] pend;

  // assemble code from bytes as they will stand after this cycle
  always_comb begin
    next_low = wr_low_i ? wdata_i : low_o;
    next_high = wr_high_i ? wdata_i : high_o;
    if (mode8_i) begin
      pend = {{(CW-DATA_W){1'b0}}, next_low};
    end else begin
      pend = {next_high[NIB_W-1:0], next_low};
    end
    next_code = code_o;
    // immediate update only on low byte so high-then-low is atomic
    if (sync_i && wr_low_i) begin
      next_code = pend;
    end
    if (sync_rise_i) begin
      next_code = pend;
    end
  end

  // register bytes and live code
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_o <= CODE_RESET;
      high_o <= CODE_RESET;
      code_o <= '0;
    end else begin
      low_o <= next_low;
      high_o <= next_high;
      code_o <= next_code;
    end
  end
endmodule

// file: rtl/dac_ctl.sv
// dual converter control and data registers on the special-function bus
`timescale 1ns/1ps
module dac_ctl
  import dac_ctl_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [dac_ctl_pkg::ADDR_W-1:0] SFR_ADDR_I,
  input wire logic [dac_ctl_pkg::DATA_W-1:0] SFR_WDATA_I,
  output logic [dac_ctl_pkg::DATA_W-1:0] SFR_RDATA_O,
  output logic SFR_HIT_O,
  output logic [dac_ctl_pkg::CODE_W-1:0] CHAN0_CODE_O,
  output logic [dac_ctl_pkg::CODE_W-1:0] CHAN1_CODE_O,
  output logic CHAN0_RANGE_SELECT_O,
  output logic CHAN1_RANGE_SELECT_O,
  output logic CHAN0_ZERO_FORCE_N_O,
  output logic CHAN1_ZERO_FORCE_N_O,
  output logic CHAN0_POWER_ON_O,
  output logic CHAN1_POWER_ON_O,
  output logic CHAN0_OUT_EN_O,
  output logic CHAN1_OUT_EN_O
);
  import dac_ctl_pkg::*;

  logic [DATA_W-1:0] converter_control;
  logic [DATA_W-1:0] next_control;
  logic wr_ctrl;
  logic sync_rise;
  logic [DATA_W-1:0] low_byte [NCHAN];
  logic [DATA_W-1:0] high_byte [NCHAN];
  logic [CODE_W-1:0] code [NCHAN];
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] rdata;

  // write decode of the control register
  assign wr_ctrl = SFR_WR_I && (SFR_ADDR_I == ADDR_CTRL);

  // a 0 to 1 write of the sync bit releases both pending codes at once
  assign sync_rise = wr_ctrl && SFR_WDATA_I[BIT_SYNC] && !converter_control[BIT_SYNC];

  // next control value
  always_comb begin
    next_control = wr_ctrl ? SFR_WDATA_I : converter_control;
  end

  // control register, resets with both channels off
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      converter_control <= CTRL_RESET;
    end else begin
      converter_control <= next_control;
    end
  end

  // one data path per channel; mode and sync are shared, so both see the same control
  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    localparam logic [ADDR_W-1:0] LOW_A = (c == 0) ? ADDR_CH0_LOW : ADDR_CH1_LOW;
    localparam logic [ADDR_W-1:0] HIGH_A = (c == 0) ? ADDR_CH0_HIGH : ADDR_CH1_HIGH;
    dac_chan u_chan (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .wr_low_i(SFR_WR_I && (SFR_ADDR_I == LOW_A)),
      .wr_high_i(SFR_WR_I && (SFR_ADDR_I == HIGH_A)),
      .wdata_i(SFR_WDATA_I),
      .mode8_i(converter_control[BIT_MODE8]),
      .sync_i(converter_control[BIT_SYNC]),
      .sync_rise_i(sync_rise),
      .low_o(low_byte[c]),
      .high_o(high_byte[c]),
      .code_o(code[c])
    );
  end

  // live codes to the converter cores
  assign CHAN0_CODE_O = code[0];
  assign CHAN1_CODE_O = code[1];

  // analog controls straight from the register bits
  assign CHAN1_RANGE_SELECT_O = converter_control[BIT_RANGE1];
  assign CHAN0_RANGE_SELECT_O = converter_control[BIT_RANGE0];
  assign CHAN1_ZERO_FORCE_N_O = converter_control[BIT_ZERO1_N];
  assign CHAN0_ZERO_FORCE_N_O = converter_control[BIT_ZERO0_N];
  assign CHAN1_POWER_ON_O = converter_control[BIT_PWR1];
  assign CHAN0_POWER_ON_O = converter_control[BIT_PWR0];
  // output stage floats whenever its channel is powered off
  assign CHAN1_OUT_EN_O = converter_control[BIT_PWR1];
  assign CHAN0_OUT_EN_O = converter_control[BIT_PWR0];

  // read mux, registered so data lands one cycle after the strobe
  always_comb begin
    unique case (SFR_ADDR_I)
      ADDR_CH0_LOW: next_rdata = low_byte[0];
      ADDR_CH0_HIGH: next_rdata = high_byte[0];
      ADDR_CH1_LOW: next_rdata = low_byte[1];
      ADDR_CH1_HIGH: next_rdata = high_byte[1];
      ADDR_CTRL: next_rdata = converter_control;
      default: next_rdata = '0;
    endcase
    if (!SFR_RD_I) begin
      next_rdata = rdata;
    end
  end

  // read data register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end
  assign SFR_RDATA_O = rdata;

  // hit flag lets the core merge several peripherals' read data
  assign SFR_HIT_O = (SFR_ADDR_I >= ADDR_CH0_LOW) && (SFR_ADDR_I <= ADDR_CTRL);
endmodule

// file: rtl/dac_ctl_pkg.sv
// constants shared by the dual converter control block
// What this block does
// - two channels, 12-bit or 8-bit codes
// - 12-bit immediate: low byte write updates output
// - control bit 7 high selects 8-bit mode
// - control bit 6 sets channel 1 range
// - control bit 5 sets channel 0 range
// - control bit 4 low zeroes channel 1
// - control bit 3 low zeroes channel 0
// - sync bit high: low byte write updates
// - sync rising edge loads both pending codes
// - control bit 1 powers channel 1
// - control bit 0 powers channel 0
// - codes right-justified, high nibble upper bits
// - after reset channels off, outputs high impedance
package dac_ctl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;
  localparam int NIB_W = 4;
  localparam int NCHAN = 2;
  localparam logic [ADDR_W-1:0] ADDR_CH0_LOW = 8'hf9;
  localparam logic [ADDR_W-1:0] ADDR_CH0_HIGH = 8'hfa;
  localparam logic [ADDR_W-1:0] ADDR_CH1_LOW = 8'hfb;
  localparam logic [ADDR_W-1:0] ADDR_CH1_HIGH = 8'hfc;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'hfd;
  localparam logic [DATA_W-1:0] CODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h04;
  localparam int BIT_MODE8 = 7;
  localparam int BIT_RANGE1 = 6;
  localparam int BIT_RANGE0 = 5;
  localparam int BIT_ZERO1_N = 4;
  localparam int BIT_ZERO0_N = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_PWR1 = 1;
  localparam int BIT_PWR0 = 0;
endpackage

// file: tb/dac_core.sv
// behavioural converter core at the far side of one channel
`timescale 1ns/1ps
module dac_core (
  input wire logic [11:0] code_i,
  input wire logic zero_n_i,
  input wire logic en_i,
  output logic [11:0] level_o
);
  // reference-range levels assume software keeps the sampling converter running
  // a disabled stage floats and the board pull-down holds it at ground
  always_comb level_o = (en_i && zero_n_i) ? code_i : 12'h000;
endmodule

// file: tb/dac_ctl_monitor.sv
// assertion checker for the dual converter control block
`timescale 1ns/1ps
module dac_ctl_monitor (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [11:0] CHAN0_CODE_O,
  input wire logic [11:0] CHAN1_CODE_O,
  input wire logic CHAN0_RANGE_SELECT_O,
  input wire logic CHAN1_RANGE_SELECT_O,
  input wire logic CHAN0_ZERO_FORCE_N_O,
  input wire logic CHAN1_ZERO_FORCE_N_O,
  input wire logic CHAN0_POWER_ON_O,
  input wire logic CHAN1_POWER_ON_O,
  input wire logic CHAN0_OUT_EN_O,
  input wire logic CHAN1_OUT_EN_O
);
  logic [7:0] ctl, next_ctl;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_wr(a);
    SFR_WR_I && SFR_ADDR_I == a;
  endsequence
  // shadow control byte, so mode and sync are known at each data write
  always_comb next_ctl = (SFR_WR_I && SFR_ADDR_I == 8'hfd) ? SFR_WDATA_I : ctl;
  always_ff @(posedge CLK_I) ctl <= SRST_I ? 8'h04 : next_ctl;
  a_ctl_fields:
    assert property (s_wr(8'hfd) |=> {CHAN1_RANGE_SELECT_O, CHAN0_RANGE_SELECT_O,
      CHAN1_ZERO_FORCE_N_O, CHAN0_ZERO_FORCE_N_O} == $past(SFR_WDATA_I[6:3]))
      else $error("bad fields");
  a_power_bits:
    assert property (s_wr(8'hfd) |=> {CHAN1_POWER_ON_O, CHAN0_POWER_ON_O}
      == $past(SFR_WDATA_I[1:0])) else $error("bad power");
  a_out_enable:
    assert property ({CHAN1_OUT_EN_O, CHAN0_OUT_EN_O} == {CHAN1_POWER_ON_O, CHAN0_POWER_ON_O})
      else $error("bad enable");
  a_reset_off:
    assert property ($past(SRST_I) |-> !CHAN0_OUT_EN_O && !CHAN1_OUT_EN_O) else $error("on");
  a_imm8_chan0:
    assert property (s_wr(8'hf9) ##0 ctl[7] && ctl[2] |=> CHAN0_CODE_O
      == {4'h0, $past(SFR_WDATA_I)}) else $error("bad code 0");
  a_imm8_chan1:
    assert property (s_wr(8'hfb) ##0 ctl[7] && ctl[2] |=> CHAN1_CODE_O
      == {4'h0, $past(SFR_WDATA_I)}) else $error("bad code 1");
  a_pending_hold:
    assert property (s_wr(8'hf9) ##0 !ctl[2] |=> $stable(CHAN0_CODE_O)) else $error("moved");
  a_code_quiet:
    assert property (!$past(SFR_WR_I) && !$past(SRST_I) |-> $stable(CHAN0_CODE_O)
      && $stable(CHAN1_CODE_O)) else $error("code moved");
endmodule
bind dac_ctl dac_ctl_monitor mon_u (.*);

// file: tb/dac_ctl_test.sv
// self-checking bench for the dual converter control block
`timescale 1ns/1ps
module dac_ctl_test;
  logic CLK_I = 0, SRST_I = 1, SFR_WR_I = 0, SFR_RD_I = 0, SFR_HIT_O;
  logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, SFR_RDATA_O;
  logic [11:0] CHAN0_CODE_O, CHAN1_CODE_O, lvl0, lvl1;
  logic CHAN0_RANGE_SELECT_O, CHAN1_RANGE_SELECT_O, CHAN0_ZERO_FORCE_N_O, CHAN1_ZERO_FORCE_N_O;
  logic CHAN0_POWER_ON_O, CHAN1_POWER_ON_O, CHAN0_OUT_EN_O, CHAN1_OUT_EN_O;
  int n_mismatch = 0, checks = 0;
  wire [23:0] codes = {CHAN1_CODE_O, CHAN0_CODE_O};
  wire [23:0] lv = {lvl1, lvl0};
  wire [7:0] flags = {CHAN1_OUT_EN_O, CHAN0_OUT_EN_O, CHAN1_POWER_ON_O, CHAN0_POWER_ON_O,
    CHAN1_ZERO_FORCE_N_O, CHAN0_ZERO_FORCE_N_O, CHAN1_RANGE_SELECT_O, CHAN0_RANGE_SELECT_O};
  // core clock, 5 ns period
  initial forever #2.5 CLK_I = ~CLK_I;
  dac_ctl dut_u (.*);
  dac_core core0_u (.code_i(CHAN0_CODE_O), .zero_n_i(CHAN0_ZERO_FORCE_N_O),
    .en_i(CHAN0_OUT_EN_O), .level_o(lvl0));
  dac_core core1_u (.code_i(CHAN1_CODE_O), .zero_n_i(CHAN1_ZERO_FORCE_N_O),
    .en_i(CHAN1_OUT_EN_O), .level_o(lvl1));
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one strobe per access, a gap cycle after it so no strobe is set twice in one step
  task wreg(input logic [7:0] a, d, input logic w = 1);
    @(posedge CLK_I);
    SFR_WR_I <= w;
    SFR_RD_I <= !w;
    SFR_ADDR_I <= a;
    SFR_WDATA_I <= d;
    @(posedge CLK_I);
    SFR_WR_I <= 0;
    SFR_RD_I <= 0;
    #1;
  endtask
  task rreg(input logic [7:0] a, e);
    wreg(a, 8'h00, 0);
    chk(SFR_RDATA_O, e);
  endtask
  task final_report;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // resets, immediate, simultaneous and 8-bit updates, then channel 1 power down
  initial begin
    repeat (5) @(posedge CLK_I);
    SRST_I <= 0;
    for (int i = 0; i < 6; i++) begin
      rreg(8'(8'hf8 + i), i == 5 ? 8'h04 : 8'h00);
      chk(SFR_HIT_O, i != 0);
    end
    chk({flags, lv}, 32'h0);
    wreg(8'hfd, 8'h1f);
    wreg(8'hfa, 8'hf5);
    chk({flags, codes}, 32'hfc000000);
    wreg(8'hf9, 8'h67);
    wreg(8'hfc, 8'h0a);
    wreg(8'hfb, 8'hbc);
    chk(lv, 24'habc567);
    rreg(8'hfa, 8'hf5);
    wreg(8'hfd, 8'h07);
    chk({flags, lv}, 32'hf0000000);
    wreg(8'hfd, 8'h1b);
    wreg(8'hf9, 8'h11);
    wreg(8'hfb, 8'h22);
    chk(codes, 24'habc567);
    wreg(8'hfd, 8'h1f);
    chk(codes, 24'ha22511);
    wreg(8'hfd, 8'hbf);
    wreg(8'hf9, 8'h80);
    wreg(8'hfb, 8'hff);
    chk({flags, codes}, 32'hfd0ff080);
    wreg(8'hfd, 8'h41);
    chk({flags, lv}, 32'h52000000);
    // mid-run reset must drop power, codes and data bytes again
    @(posedge CLK_I);
    SRST_I <= 1;
    @(posedge CLK_I);
    SRST_I <= 0;
    #1;
    chk({flags, codes}, 32'h0);
    rreg(8'hfd, 8'h04);
    rreg(8'hf9, 8'h00);
    final_report;
  end
endmodule
